//--- src/input_terminal_function_router.sv
// Input terminal function router with APB selector registers
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

//Contract
// - Seven selectors with documented reset codes
// - Decode 10,12,14,15,18,24,25,62
// - Remote setting reinterprets speed codes
// - Stop-on-contact reinterprets codes 0, 3
// - Thermal trip active on open contact
// - Shared codes OR their terminals
// - Jog over multi-speed over PID
// - Output stop doubles as enable
// - Output stop doubles as interlock in operation mode 7
// - V/F change applied only when stopped
// - V/F while running enables second set
// - Current input masks voltage input
// - Enable and output stop within 2ms
// - Other functions within 20ms
// - Output-stop selector only under communication
// - Speed and remote share terminals
// - Brake feedback feeds brake sequence
module input_terminal_function_router
	import term_router_pkg::*;
(
	input  wire logic        CLK_SYS,          // System clock, 125 MHz
	input  wire logic        RST,              // Synchronous reset, active high
	input  wire logic        PSEL,             // APB select
	input  wire logic        PENABLE,          // APB enable
	input  wire logic        PWRITE,           // APB direction
	input  wire logic [11:0] PADDR,            // APB byte address
	input  wire logic [31:0] PWDATA,           // APB write data
	output logic      [31:0] PRDATA,           // APB read data
	output logic             PREADY,           // APB ready
	output logic             PSLVERR,          // APB error
	input  wire logic [6:0]  TERM_IN,          // Terminal contacts, 1 = closed
	input  wire logic        COMM_OSTOP,       // Output-stop bit from communication
	input  wire logic        DRIVE_RUNNING,    // Drive is running
	output logic             FORWARD_START,    // Forward start
	output logic             REVERSE_START,    // Reverse start
	output logic             LOW_SPEED,        // Low speed step
	output logic             MID_SPEED,        // Middle speed step
	output logic             HIGH_SPEED,       // High speed step
	output logic             REMOTE_CLEAR,     // Remote setting clear
	output logic             REMOTE_DECEL,     // Remote decelerate
	output logic             REMOTE_ACCEL,     // Remote accelerate
	output logic             STOPC_SEL0,       // Stop-on-contact select 0
	output logic             STOPC_SEL1,       // Stop-on-contact select 1
	output logic             SECOND_SET,       // Second parameter set
	output logic             VOLTAGE_IN_EN,    // Voltage analog input usable
	output logic             JOG_SELECT,       // Jog
	output logic             THERMAL_TRIP,     // External thermal trip
	output logic             FIFTEEN_SPEED,    // Fifteen speed extension
	output logic             OPERATION_ENABLE, // Operation enable
	output logic             PANEL_INTERLOCK,  // Panel operation interlock
	output logic             PID_ACTIVE,       // PID command in use
	output logic             BRAKE_CONFIRM,    // Brake released confirmation
	output logic             VF_CONTROL,       // V/F control applied
	output logic             OUTPUT_STOP,      // Output stop
	output logic             START_HOLD,       // Start self-hold
	output logic             DRIVE_RESET,      // Drive reset
	output logic             SEL_EXTERNAL,     // External operation select
	output logic             SEL_PANEL,        // Panel operation select
	output logic             SEL_NETWORK,      // Network operation select
	output logic             ALT_CMD_SOURCE,   // Alternative command source
	output logic [3:0]       SPEED_SOURCE      // One-hot speed source
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [NUM_TERM-1:0][13:0] sel;
		logic [9:0]                mode;
		logic [NUM_TERM-1:0]       meta;
		logic [NUM_TERM-1:0]       sync;
		logic [NUM_TERM-1:0]       filt;
		logic [NUM_TERM-1:0][21:0] cnt;
		logic                      comm_meta;
		logic                      comm_sync;
		logic                      vf_applied;
		logic [NUM_TERM-1:0]       reject;
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
		logic [33:0]               outs;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [NUM_TERM-1:0] fast_term;
	logic [33:0]         o;

	// A terminal's filter runs fast only when it carries a fast function (output stop or operation enable)
	generate
		for (genvar t = 0; t < NUM_TERM; t++) begin : g_fast
			assign fast_term[t] = (s_q.sel[t] == FC_OSTOP) || (s_q.sel[t] == FC_OPEN);
		end
	endgenerate

	// Code legality per selector
	function automatic logic code_ok(input int t, input logic [13:0] c);
		logic ok;
		ok = (c <= FC_JOG) || (c == FC_THERMAL) || (c == FC_REX) || (c == FC_OPEN) ||
			(c == FC_ILOCK) || ((c >= FC_PID) && (c <= FC_PUEXT)) || (c == FC_VF) ||
			(c == FC_OSTOP) || (c == FC_HOLD) || (c == FC_RESET) ||
			((c >= FC_PUNET) && (c <= FC_CMDSRC)) || (c == FC_NONE);
		if (c == FC_FWD) begin
			ok = (t == 0);
		end else if (c == FC_REV) begin
			ok = (t == 1);
		end
		return ok;
	endfunction

	// OR of all terminals assigned to one code
	function automatic logic any_on(input state_t s, input logic [NUM_TERM-1:0] v, input logic [13:0] c);
		logic r;
		r = 1'b0;
		for (int t = 0; t < NUM_TERM; t++) begin
			if (s.sel[t] == c) begin
				r = r | v[t];
			end
		end
		return r;
	endfunction

	function automatic logic assigned(input state_t s, input logic [13:0] c);
		logic r;
		r = 1'b0;
		for (int t = 0; t < NUM_TERM; t++) begin
			r = r | (s.sel[t] == c);
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [NUM_TERM-1:0] eff;
		logic                remote;
		logic                stopc;
		logic                ostop;
		logic                vf_req;
		logic                jog;
		logic                multi;
		logic                pid;
		logic [13:0]         wcode;
		logic [21:0]         lim;
		int                  idx;
		eff    = '0;
		remote = 1'b0;
		stopc  = 1'b0;
		ostop  = 1'b0;
		vf_req = 1'b0;
		jog    = 1'b0;
		multi  = 1'b0;
		pid    = 1'b0;
		wcode  = PWDATA[13:0];
		lim    = '0;
		idx    = 0;
		s_d    = s_q;
		o      = '0;

		// Two-stage synchronisers on pins
		s_d.meta      = TERM_IN;
		s_d.sync      = s_q.meta;
		s_d.comm_meta = COMM_OSTOP;
		s_d.comm_sync = s_q.comm_meta;

		for (int t = 0; t < NUM_TERM; t++) begin
			lim = fast_term[t] ? 22'(FAST_CYCLES) : 22'(SLOW_CYCLES);
			if (s_q.sync[t] == s_q.filt[t]) begin
				s_d.cnt[t] = '0;
			end else if (s_q.cnt[t] >= lim - 22'h1) begin
				s_d.filt[t] = s_q.sync[t];
				s_d.cnt[t]  = '0;
			end else begin
				s_d.cnt[t] = s_q.cnt[t] + 22'h1;
			end
		end

		// output-stop terminal follows communication bit in comm source
		eff = s_q.filt;
		if (s_q.mode[COMM_SRC_BIT]) begin
			eff[OSTOP_TERM] = s_q.comm_sync;
		end

		// APB slave, answers in the access cycle
		s_d.pready  = 1'b0;
		s_d.pslverr = 1'b0;
		if (PSEL && !PENABLE) begin
			s_d.pready = 1'b1;
			s_d.prdata = '0;
			idx        = int'(PADDR[4:2]);
			if ((PADDR < MODE_CFG_ADDR) && (PADDR[1:0] == 2'b00) && (idx < NUM_TERM)) begin
				s_d.prdata = 32'(s_q.sel[idx]);
				if (PWRITE && code_ok(idx, wcode) && (PWDATA[31:14] == '0)) begin
					s_d.sel[idx] = wcode;
				end else if (PWRITE) begin
					s_d.reject[idx] = 1'b1;
					s_d.pslverr     = 1'b1;
				end
			end else if (PADDR == MODE_CFG_ADDR) begin
				s_d.prdata = 32'(s_q.mode);
				if (PWRITE) begin
					s_d.mode = PWDATA[9:0];
				end
			end else if (PADDR == TERM_STAT_ADDR) begin
				s_d.prdata = 32'(s_q.filt);
			end else if (PADDR == FUNC_STAT_ADDR) begin
				s_d.prdata = {1'b0, s_q.outs[30:0]};
			end else if (PADDR == REJECT_STAT_ADDR) begin
				s_d.prdata = 32'(s_q.reject);
				// Write one to clear reject flags
				if (PWRITE) begin
					s_d.reject = s_q.reject & ~PWDATA[6:0];
				end
			end else begin
				s_d.pslverr = 1'b1;
			end
		end

		// Function decode
		remote = (s_q.mode[REMOTE_LSB +: 2] == 2'h1) || (s_q.mode[REMOTE_LSB +: 2] == 2'h2);
		stopc  = s_q.mode[STOPC_BIT];
		o[0]   = any_on(s_q, eff, FC_FWD);
		o[1]   = any_on(s_q, eff, FC_REV);
		o[2]   = any_on(s_q, eff, FC_LOW) && !remote && !stopc;
		o[3]   = any_on(s_q, eff, FC_MID) && !remote;
		o[4]   = any_on(s_q, eff, FC_HIGH) && !remote;
		o[5]   = any_on(s_q, eff, FC_LOW) && remote && !stopc;
		o[6]   = any_on(s_q, eff, FC_MID) && remote;
		o[7]   = any_on(s_q, eff, FC_HIGH) && remote;
		o[8]   = any_on(s_q, eff, FC_LOW) && stopc;
		o[9]   = any_on(s_q, eff, FC_SECOND) && stopc;
		o[11]  = !any_on(s_q, eff, FC_CURIN);
		jog    = any_on(s_q, eff, FC_JOG);
		o[12]  = jog;
		// open contact means trip; unassigned stays quiet
		o[13]  = assigned(s_q, FC_THERMAL) && !any_on(s_q, eff, FC_THERMAL);
		o[14]  = any_on(s_q, eff, FC_REX);
		// output stop ORs all its terminals
		ostop  = any_on(s_q, eff, FC_OSTOP);
		o[20]  = ostop;
		o[15]  = assigned(s_q, FC_OPEN) ? any_on(s_q, eff, FC_OPEN) : ostop;
		// interlock shared in operation mode 7
		o[16]  = assigned(s_q, FC_ILOCK) ? any_on(s_q, eff, FC_ILOCK) :
			((s_q.mode[OPMODE_LSB +: 4] == OPMODE_ILOCK) && ostop);
		// brake feedback only in brake sequence mode
		o[18]  = s_q.mode[BRAKE_BIT] && any_on(s_q, eff, FC_BRAKE);
		vf_req = any_on(s_q, eff, FC_VF);
		if (!DRIVE_RUNNING) begin
			s_d.vf_applied = vf_req;
		end
		o[19]  = s_q.vf_applied;
		// V/F requested while running enables second set at once
		o[10]  = (any_on(s_q, eff, FC_SECOND) && !stopc) || vf_req;
		o[21]  = any_on(s_q, eff, FC_HOLD);
		o[22]  = any_on(s_q, eff, FC_RESET);
		o[23]  = any_on(s_q, eff, FC_PUEXT);
		o[24]  = any_on(s_q, eff, FC_PUNET);
		o[25]  = any_on(s_q, eff, FC_EXTNET);
		o[26]  = any_on(s_q, eff, FC_CMDSRC);
		multi  = o[2] || o[3] || o[4] || o[14];
		pid    = any_on(s_q, eff, FC_PID);
		o[17]  = pid && !jog && !multi;
		if (jog) begin
			o[30:27] = SPD_JOG;
		end else if (multi) begin
			o[30:27] = SPD_MULTI;
		end else if (pid) begin
			o[30:27] = SPD_PID;
		end else begin
			o[30:27] = SPD_NONE;
		end
		s_d.outs = o;

		if (RST) begin
			s_d = '0;
			for (int t = 0; t < NUM_TERM; t++) begin
				s_d.sel[t] = SEL_RESET[t];
			end
			s_d.outs[11]    = 1'b1;
			s_d.outs[30:27] = SPD_NONE;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		s_q <= s_d;
	end

	// Outputs straight from the state register
	assign PRDATA           = s_q.prdata;
	assign PREADY           = s_q.pready;
	assign PSLVERR          = s_q.pslverr;
	assign FORWARD_START    = s_q.outs[0];
	assign REVERSE_START    = s_q.outs[1];
	assign LOW_SPEED        = s_q.outs[2];
	assign MID_SPEED        = s_q.outs[3];
	assign HIGH_SPEED       = s_q.outs[4];
	assign REMOTE_CLEAR     = s_q.outs[5];
	assign REMOTE_DECEL     = s_q.outs[6];
	assign REMOTE_ACCEL     = s_q.outs[7];
	assign STOPC_SEL0       = s_q.outs[8];
	assign STOPC_SEL1       = s_q.outs[9];
	assign SECOND_SET       = s_q.outs[10];
	assign VOLTAGE_IN_EN    = s_q.outs[11];
	assign JOG_SELECT       = s_q.outs[12];
	assign THERMAL_TRIP     = s_q.outs[13];
	assign FIFTEEN_SPEED    = s_q.outs[14];
	assign OPERATION_ENABLE = s_q.outs[15];
	assign PANEL_INTERLOCK  = s_q.outs[16];
	assign PID_ACTIVE       = s_q.outs[17];
	assign BRAKE_CONFIRM    = s_q.outs[18];
	assign VF_CONTROL       = s_q.outs[19];
	assign OUTPUT_STOP      = s_q.outs[20];
	assign START_HOLD       = s_q.outs[21];
	assign DRIVE_RESET      = s_q.outs[22];
	assign SEL_EXTERNAL     = s_q.outs[23];
	assign SEL_PANEL        = s_q.outs[24];
	assign SEL_NETWORK      = s_q.outs[25];
	assign ALT_CMD_SOURCE   = s_q.outs[26];
	assign SPEED_SOURCE     = s_q.outs[30:27];

endmodule

`default_nettype wire

//--- common/term_router_pkg.sv
// Constants and types shared by the input terminal function router
package term_router_pkg;

	// ------------------------------------------------------------
	// Bus and register map
	// ------------------------------------------------------------
	localparam int          NUM_TERM         = 7;
	localparam logic [11:0] SEL_BASE_ADDR    = 12'h000; // Selector n at base + 4n
	localparam logic [11:0] MODE_CFG_ADDR    = 12'h020;
	localparam logic [11:0] TERM_STAT_ADDR   = 12'h024;
	localparam logic [11:0] FUNC_STAT_ADDR   = 12'h028;
	localparam logic [11:0] REJECT_STAT_ADDR = 12'h02c;

	// Mode configuration field positions
	localparam int REMOTE_LSB   = 0;  // Remote function setting, 2 bits
	localparam int STOPC_BIT    = 2;  // Stop-on-contact setting
	localparam int OPMODE_LSB   = 4;  // Operation mode setting, 4 bits
	localparam int BRAKE_BIT    = 8;  // Brake sequence mode
	localparam int COMM_SRC_BIT = 9;  // Communication command source

	// ------------------------------------------------------------
	// Function codes
	// ------------------------------------------------------------
	localparam logic [13:0] FC_LOW     = 14'h0000;
	localparam logic [13:0] FC_MID     = 14'h0001;
	localparam logic [13:0] FC_HIGH    = 14'h0002;
	localparam logic [13:0] FC_SECOND  = 14'h0003;
	localparam logic [13:0] FC_CURIN   = 14'h0004;
	localparam logic [13:0] FC_JOG     = 14'h0005;
	localparam logic [13:0] FC_THERMAL = 14'h0007;
	localparam logic [13:0] FC_REX     = 14'h0008;
	localparam logic [13:0] FC_OPEN    = 14'h000a;
	localparam logic [13:0] FC_ILOCK   = 14'h000c;
	localparam logic [13:0] FC_PID     = 14'h000e;
	localparam logic [13:0] FC_BRAKE   = 14'h000f;
	localparam logic [13:0] FC_PUEXT   = 14'h0010;
	localparam logic [13:0] FC_VF      = 14'h0012;
	localparam logic [13:0] FC_OSTOP   = 14'h0018;
	localparam logic [13:0] FC_HOLD    = 14'h0019;
	localparam logic [13:0] FC_FWD     = 14'h003c;
	localparam logic [13:0] FC_REV     = 14'h003d;
	localparam logic [13:0] FC_RESET   = 14'h003e;
	localparam logic [13:0] FC_PUNET   = 14'h0041;
	localparam logic [13:0] FC_EXTNET  = 14'h0042;
	localparam logic [13:0] FC_CMDSRC  = 14'h0043;
	localparam logic [13:0] FC_NONE    = 14'h270f;

	// Selector reset values, terminal 0..6
	localparam logic [13:0] SEL_RESET [NUM_TERM] = '{FC_FWD, FC_REV, FC_LOW, FC_MID, FC_HIGH, FC_OSTOP, FC_RESET};
	localparam logic [3:0]  OPMODE_ILOCK         = 4'h7;
	localparam int          OSTOP_TERM           = 5;

	// ------------------------------------------------------------
	// Response timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ       = 125;
	localparam int FAST_TIME_US  = 2000;  // 2 ms
	localparam int SLOW_TIME_US  = 20000; // 20 ms
	// Filters settle well inside the limit: a quarter of each bound
	localparam int FAST_CYCLES   = FAST_TIME_US * CLK_MHZ / 4;
	localparam int SLOW_CYCLES   = SLOW_TIME_US * CLK_MHZ / 4;

	// Speed source chosen by priority
	typedef enum logic [3:0] {
		SPD_NONE  = 4'b0001,
		SPD_PID   = 4'b0010,
		SPD_MULTI = 4'b0100,
		SPD_JOG   = 4'b1000
	} speed_src_t;

endpackage

//--- verif/router_monitor.sv
// Concurrent checks on the terminal router ports
`timescale 1ns/1ps
`default_nettype none
module router_monitor
	import term_router_pkg::*;
(
	input wire logic        CLK_SYS,       // System clock
	input wire logic        RST,           // Synchronous reset
	input wire logic        PSEL,          // APB select
	input wire logic        PENABLE,       // APB enable
	input wire logic        PWRITE,        // APB direction
	input wire logic [11:0] PADDR,         // APB address
	input wire logic [31:0] PWDATA,        // APB write data
	input wire logic        PREADY,        // APB ready
	input wire logic        PSLVERR,       // APB error
	input wire logic        DRIVE_RUNNING, // Drive running
	input wire logic        LOW_SPEED,     // Low speed step
	input wire logic        MID_SPEED,     // Middle speed step
	input wire logic        HIGH_SPEED,    // High speed step
	input wire logic        REMOTE_CLEAR,  // Remote clear
	input wire logic        STOPC_SEL0,    // Stop-on-contact select 0
	input wire logic        JOG_SELECT,    // Jog
	input wire logic        PID_ACTIVE,    // PID command
	input wire logic        VF_CONTROL,    // V/F applied
	input wire logic [3:0]  SPEED_SOURCE   // Speed source
);
	// ------------------------------------------------------------
	// Port relations
	// ------------------------------------------------------------
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	// Zero-wait slave: the answer lands in the access cycle
	ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("ready missing after setup");
	ready_in_access_a: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE))
		else $error("ready outside access phase");
	start_code_lock_a: assert property (
		PSEL && !PENABLE && PWRITE && PADDR < MODE_CFG_ADDR && PADDR[1:0] == 2'b00 &&
		((PADDR != 12'h000 && PWDATA == 32'h3c) || (PADDR != 12'h004 && PWDATA == 32'h3d)) |=> PSLVERR)
		else $error("start code taken on wrong selector");
	code_range_a: assert property (
		PSEL && !PENABLE && PWRITE && PADDR < MODE_CFG_ADDR && PWDATA > 32'h270f |=> PSLVERR)
		else $error("out of range code taken");
	remote_swap_a: assert property (!(LOW_SPEED && REMOTE_CLEAR))
		else $error("speed step and remote clear together");
	contact_swap_a: assert property (!(STOPC_SEL0 && (LOW_SPEED || REMOTE_CLEAR)))
		else $error("stop-on-contact not exclusive");
	jog_first_a: assert property (JOG_SELECT |-> SPEED_SOURCE == SPD_JOG)
		else $error("jog not first");
	pid_last_a: assert property (PID_ACTIVE |-> !JOG_SELECT && !LOW_SPEED && !MID_SPEED && !HIGH_SPEED)
		else $error("pid over higher source");
	onehot_src_a: assert property ($onehot(SPEED_SOURCE))
		else $error("speed source not one-hot");
	vf_deferred_a: assert property ($changed(VF_CONTROL) |-> !$past(DRIVE_RUNNING) || !$past(DRIVE_RUNNING, 2))
		else $error("control method changed while running");
endmodule
`default_nettype wire

//--- verif/contact_bank.sv
// Terminal contact model with bounce after every change
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
	input  wire logic       clk,   // Sampling clock
	input  wire logic [6:0] want,  // Intended contact state
	output logic      [6:0] level  // Level at the terminals
);
	// ------------------------------------------------------------
	// Bounce
	// ------------------------------------------------------------
	logic [6:0] last_q    = 7'h00;
	logic [2:0] chatter_q = 3'h0;
	initial level = 7'h00;
	// Real contacts chatter, so each change toggles a few cycles first
	always @(posedge clk) begin
		last_q <= want;
		chatter_q <= (want != last_q) ? 3'h5 : chatter_q - ((chatter_q != 3'h0) ? 3'h1 : 3'h0);
		level <= last_q ^ {7{chatter_q[0]}};
	end
endmodule
`default_nettype wire

//--- verif/input_terminal_function_router_tb.sv
// Self-checking bench for the input terminal function router
`timescale 1ns/1ps
`default_nettype none
module input_terminal_function_router_tb;
	import term_router_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and bookkeeping
	// ------------------------------------------------------------
	localparam logic [13:0] CODES [23] = '{FC_LOW, FC_MID, FC_HIGH, FC_SECOND, FC_CURIN, FC_JOG, FC_THERMAL,
		FC_REX, FC_OPEN, FC_ILOCK, FC_PID, FC_BRAKE, FC_PUEXT, FC_VF, FC_OSTOP, FC_HOLD, FC_FWD, FC_REV,
		FC_RESET, FC_PUNET, FC_EXTNET, FC_CMDSRC, FC_NONE};
	logic        clk_sys    = 1'b0;
	logic        rst        = 1'b1;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [11:0] paddr      = 12'h000;
	logic [31:0] pwdata     = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [6:0]  want       = 7'h00;
	logic [6:0]  term_in;
	logic        comm_ostop = 1'b0;
	logic        running    = 1'b0;
	logic [31:0] seed;
	logic [31:0] code;
	logic [31:0] rd;
	logic        er;
	logic        ok;
	logic [13:0] ref_sel [NUM_TERM];
	logic [30:0] fo;
	logic [9:0]  m;
	int          i;
	int          k;
	int          pass_n;
	int          failures    = 0;
	int          comparisons = 0;

	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	input_terminal_function_router DUT (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TERM_IN(term_in), .COMM_OSTOP(comm_ostop), .DRIVE_RUNNING(running), .FORWARD_START(fo[0]),
		.REVERSE_START(fo[1]), .LOW_SPEED(fo[2]), .MID_SPEED(fo[3]), .HIGH_SPEED(fo[4]), .REMOTE_CLEAR(fo[5]),
		.REMOTE_DECEL(fo[6]), .REMOTE_ACCEL(fo[7]), .STOPC_SEL0(fo[8]), .STOPC_SEL1(fo[9]), .SECOND_SET(fo[10]),
		.VOLTAGE_IN_EN(fo[11]), .JOG_SELECT(fo[12]), .THERMAL_TRIP(fo[13]), .FIFTEEN_SPEED(fo[14]),
		.OPERATION_ENABLE(fo[15]), .PANEL_INTERLOCK(fo[16]), .PID_ACTIVE(fo[17]), .BRAKE_CONFIRM(fo[18]),
		.VF_CONTROL(fo[19]), .OUTPUT_STOP(fo[20]), .START_HOLD(fo[21]), .DRIVE_RESET(fo[22]),
		.SEL_EXTERNAL(fo[23]), .SEL_PANEL(fo[24]), .SEL_NETWORK(fo[25]), .ALT_CMD_SOURCE(fo[26]),
		.SPEED_SOURCE(fo[30:27]));

	contact_bank u_contacts (.clk(clk_sys), .want(want), .level(term_in));

	// ------------------------------------------------------------
	// Tasks and expectations
	// ------------------------------------------------------------
	task automatic complete_run;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until ready is sampled; the wait is bounded
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			failures++;
			complete_run();
		end
	endtask

	// Start codes belong to their own terminal only
	function automatic logic legal(input logic [31:0] c, input int n);
		if (c == 32'(FC_FWD)) return n == 0;
		if (c == 32'(FC_REV)) return n == 1;
		return c inside {[FC_LOW:FC_JOG], FC_THERMAL, FC_REX, FC_OPEN, FC_ILOCK, [FC_PID:FC_PUEXT], FC_VF,
			FC_OSTOP, FC_HOLD, FC_RESET, [FC_PUNET:FC_CMDSRC], FC_NONE};
	endfunction

	// Function word expected when the communication-fed terminal is the only source
	function automatic logic [31:0] expect_func(input logic [13:0] c, input logic on, input logic [9:0] md,
		input logic run);
		logic [31:0] f;
		logic        rem;
		logic        stc;
		rem = (md[1:0] == 2'h1) || (md[1:0] == 2'h2);
		stc = md[2];
		f   = 32'h00000800;
		case (c)
			FC_LOW: f[stc ? 8 : (rem ? 5 : 2)] = on;
			FC_MID: f[rem ? 6 : 3] = on;
			FC_HIGH: f[rem ? 7 : 4] = on;
			FC_SECOND: f[stc ? 9 : 10] = on;
			FC_CURIN: f[11] = !on;
			FC_JOG: f[12] = on;
			FC_THERMAL: f[13] = !on;
			FC_REX: f[14] = on;
			FC_OPEN: f[15] = on;
			FC_ILOCK: f[16] = on;
			FC_PID: f[17] = on;
			FC_BRAKE: f[18] = on && md[8];
			FC_VF: f[19] = on && !run;
			FC_OSTOP: f[20] = on;
			FC_HOLD: f[21] = on;
			FC_RESET: f[22] = on;
			FC_PUEXT: f[23] = on;
			FC_PUNET: f[24] = on;
			FC_EXTNET: f[25] = on;
			FC_CMDSRC: f[26] = on;
			default: ;
		endcase
		// V/F drags the second set along; output stop stands in for enable, and for interlock in operation mode 7
		f[10] = f[10] || ((c == FC_VF) && on);
		f[15] = f[15] || f[20];
		f[16] = f[16] || (f[20] && (md[7:4] == OPMODE_ILOCK));
		f[30:27] = f[12] ? SPD_JOG : ((f[2] || f[3] || f[4] || f[14]) ? SPD_MULTI : (f[17] ? SPD_PID : SPD_NONE));
		return f;
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h75c2c0c3;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		for (i = 0; i < NUM_TERM; i++) begin
			apb(1'b0, SEL_BASE_ADDR + 12'(4 * i), 32'h0, rd, er);
			check(rd, 32'(SEL_RESET[i]));
			ref_sel[i] = SEL_RESET[i];
		end
		// Wrong start code on every selector is refused and flagged
		for (i = 0; i < NUM_TERM; i++) begin
			apb(1'b1, SEL_BASE_ADDR + 12'(4 * i), (i == 0) ? 32'h3d : 32'h3c, rd, er);
			check(32'(er), 32'h1);
		end
		apb(1'b0, REJECT_STAT_ADDR, 32'h0, rd, er);
		check(32'(rd != 32'h0), 32'h1);
		apb(1'b1, REJECT_STAT_ADDR, 32'hffffffff, rd, er);
		apb(1'b0, REJECT_STAT_ADDR, 32'h0, rd, er);
		check(rd, 32'h0);
		apb(1'b0, 12'h030, 32'h0, rd, er);
		check({rd[30:0], er}, 32'h1);
		// Random codes and modes while contacts chatter underneath
		repeat (80) begin
			i = $unsigned($random(seed)) % NUM_TERM;
			code = ($random(seed) & 1) ? 32'(CODES[$unsigned($random(seed)) % 23]) : ($random(seed) & 32'h3fff);
			want <= 7'($random(seed));
			comm_ostop <= 1'($random(seed));
			running <= 1'($random(seed));
			apb(1'b1, SEL_BASE_ADDR + 12'(4 * i), code, rd, er);
			ok = legal(code, i);
			check(32'(er), 32'(!ok));
			if (ok) ref_sel[i] = code[13:0];
			apb(1'b0, SEL_BASE_ADDR + 12'(4 * i), 32'h0, rd, er);
			check(rd, 32'(ref_sel[i]));
			code = $random(seed) & 32'h3f7;
			apb(1'b1, MODE_CFG_ADDR, code, rd, er);
			apb(1'b0, MODE_CFG_ADDR, 32'h0, rd, er);
			check(rd, code);
		end
		// Every code but the two start codes on the communication-fed terminal, both levels; second pass while running
		for (i = 0; i < NUM_TERM; i++) begin
			apb(1'b1, SEL_BASE_ADDR + 12'(4 * i), 32'(FC_NONE), rd, er);
		end
		for (pass_n = 0; pass_n < 2; pass_n++) begin
			running <= 1'(pass_n);
			for (k = 0; k < 23; k++) begin
				if (CODES[k] == FC_FWD || CODES[k] == FC_REV) continue;
				m = 10'h200 | (10'($random(seed)) & 10'h1f7);
				if (pass_n == 1) m[7:4] = OPMODE_ILOCK;
				apb(1'b1, SEL_BASE_ADDR + 12'(4 * OSTOP_TERM), 32'(CODES[k]), rd, er);
				apb(1'b1, MODE_CFG_ADDR, 32'(m), rd, er);
				comm_ostop <= 1'b1;
				repeat (8) @(posedge clk_sys);
				apb(1'b0, FUNC_STAT_ADDR, 32'h0, rd, er);
				check(rd, expect_func(CODES[k], 1'b1, m, 1'(pass_n)));
				check(32'(fo), expect_func(CODES[k], 1'b1, m, 1'(pass_n)));
				comm_ostop <= 1'b0;
				repeat (8) @(posedge clk_sys);
				apb(1'b0, FUNC_STAT_ADDR, 32'h0, rd, er);
				check(rd, expect_func(CODES[k], 1'b0, m, 1'(pass_n)));
			end
		end
		running <= 1'b0;
		// Bursts shorter than the filters leave every function idle
		want <= 7'h00;
		comm_ostop <= 1'b0;
		apb(1'b1, MODE_CFG_ADDR, 32'h0, rd, er);
		repeat (40) @(posedge clk_sys);
		apb(1'b0, TERM_STAT_ADDR, 32'h0, rd, er);
		check(rd, 32'h0);
		apb(1'b0, FUNC_STAT_ADDR, 32'h0, rd, er);
		check(rd, 32'h08000800);
		complete_run();
	end
endmodule

bind input_terminal_function_router router_monitor u_monitor (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PWDATA, .PREADY, .PSLVERR, .DRIVE_RUNNING, .LOW_SPEED, .MID_SPEED, .HIGH_SPEED, .REMOTE_CLEAR,
	.STOPC_SEL0, .JOG_SELECT, .PID_ACTIVE, .VF_CONTROL, .SPEED_SOURCE);
`default_nettype wire
